// File: hw/gpcfg_filter.sv
// Per-pin persistence filter that hides pulses not longer than the glitch time.
`timescale 1ns/1ns
module gpcfg_filter
  import gpcfg_pkg::*;
#(
  parameter int unsigned N = 3,
  parameter int unsigned CYC = GPCFG_GLITCH_CYC
) (
  input logic clk_sys,
  input logic rst_n,
  input logic [N-1:0] raw,
  output logic [N-1:0] stable
);

  // ==========================================================================
  // Counters
  logic [N-1:0] stable_r;
  logic [N-1:0] stable_nxt;
  logic [7:0] cnt_r [N];
  logic [7:0] cnt_nxt [N];

  // A level is taken over only after CYC+1 equal samples, i.e. longer than the glitch time.
  always_comb begin
    stable_nxt = stable_r;
    for (int i = 0; i < N; i++) begin
      cnt_nxt[i] = 8'h00;
      if (raw[i] != stable_r[i]) begin
        if (cnt_r[i] == 8'(CYC)) begin
          stable_nxt[i] = raw[i];
        end else begin
          cnt_nxt[i] = cnt_r[i] + 8'h01;
        end
      end
    end
  end

  // Filtered levels start at the released-pin level, so leaving reset by itself raises no status.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stable_r <= '1;
      for (int i = 0; i < N; i++) begin
        cnt_r[i] <= 8'h00;
      end
    end else begin
      stable_r <= stable_nxt;
      for (int i = 0; i < N; i++) begin
        cnt_r[i] <= cnt_nxt[i];
      end
    end
  end

  assign stable = stable_r;

  // ==========================================================================
  // Checks
  a_filter_persist: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $changed(stable_r[0]) |-> ($past(raw[0], 1) == stable_r[0]) && ($past(raw[0], 6) == stable_r[0]))
    else $error("Filtered level changed without a persistent input.");

endmodule

// File: hw/gpcfg_pkg.sv
// Shared constants, field layout and carrier types of the pin function configuration block.
package gpcfg_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned GPCFG_CLK_PS = 8000;
  localparam int unsigned GPCFG_GLITCH_NS = 40;
  // Least time, so round up to whole cycles.
  localparam int unsigned GPCFG_GLITCH_CYC = (GPCFG_GLITCH_NS * 1000 + GPCFG_CLK_PS - 1) / GPCFG_CLK_PS;

  // ==========================================================================
  // Register map, byte addresses
  localparam logic [7:0] GPCFG_OFS_CFG = 8'h88;
  localparam logic [7:0] GPCFG_OFS_IRQ_STS = 8'h58;
  localparam logic [7:0] GPCFG_OFS_IRQ_EN = 8'h5C;
  localparam logic [31:0] GPCFG_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] GPCFG_CFG_WMASK = 32'h7777_071F;
  localparam logic [2:0] GPCFG_IRQ_RST = 3'h0;

  // ==========================================================================
  // Field positions in the configuration word
  localparam int unsigned GPCFG_LED_LSB = 28;
  localparam int unsigned GPCFG_POL_LSB = 24;
  localparam int unsigned GPCFG_ROM_LSB = 20;
  localparam int unsigned GPCFG_DRV_LSB = 16;
  localparam int unsigned GPCFG_DIR_LSB = 8;
  localparam int unsigned GPCFG_GPO_LSB = 3;
  localparam int unsigned GPCFG_DAT_LSB = 0;

  // ==========================================================================
  // Serial ROM pin selection codes
  localparam logic [2:0] GPCFG_ROM_EE = 3'h0;
  localparam logic [2:0] GPCFG_ROM_GPO = 3'h1;
  localparam logic [2:0] GPCFG_ROM_OUTPUT_ONLY_PIN_3_DV = 3'h3;
  localparam logic [2:0] GPCFG_ROM_TXEN_OUTPUT_ONLY_PIN_4 = 3'h5;
  localparam logic [2:0] GPCFG_ROM_TXEN_DV = 3'h6;
  localparam logic [2:0] GPCFG_ROM_CLKS = 3'h7;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [2:0] indicator_output_select;
    logic [2:0] pin_irq_level_polarity;
    logic [2:0] serial_rom_pin_select;
    logic [2:0] pin_driver_type;
    logic [2:0] pin_direction;
    logic [1:0] output_only_data;
    logic [2:0] pin_data;
  } gpcfg_cfg_t;

  typedef struct packed {
    logic dout;
    logic doe;
    logic clk;
  } gpcfg_rom_t;

  typedef struct packed {
    logic tx_en;
    logic rx_dv;
    logic tx_clk;
    logic rx_clk;
  } gpcfg_dbg_t;

  function automatic gpcfg_cfg_t gpcfg_unpack(input logic [31:0] w);
    gpcfg_cfg_t c;
    c.indicator_output_select = w[GPCFG_LED_LSB +: 3];
    c.pin_irq_level_polarity = w[GPCFG_POL_LSB +: 3];
    c.serial_rom_pin_select = w[GPCFG_ROM_LSB +: 3];
    c.pin_driver_type = w[GPCFG_DRV_LSB +: 3];
    c.pin_direction = w[GPCFG_DIR_LSB +: 3];
    c.output_only_data = w[GPCFG_GPO_LSB +: 2];
    c.pin_data = w[GPCFG_DAT_LSB +: 3];
    return c;
  endfunction

  function automatic logic [31:0] gpcfg_pack(input gpcfg_cfg_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[GPCFG_LED_LSB +: 3] = c.indicator_output_select;
    w[GPCFG_POL_LSB +: 3] = c.pin_irq_level_polarity;
    w[GPCFG_ROM_LSB +: 3] = c.serial_rom_pin_select;
    w[GPCFG_DRV_LSB +: 3] = c.pin_driver_type;
    w[GPCFG_DIR_LSB +: 3] = c.pin_direction;
    w[GPCFG_GPO_LSB +: 2] = c.output_only_data;
    w[GPCFG_DAT_LSB +: 3] = c.pin_data;
    return w;
  endfunction

endpackage

// File: hw/gpcfg_top.sv
// Pin function configuration register with general pin, indicator and serial ROM pin routing.
//
// What this block does
// - Indicator select bit makes shared pin an indicator output, else general pin.
// - Polarity set: high level on general pin sets its interrupt status bit.
// - Polarity clear: low level on general pin sets its interrupt status bit.
// - Pin interrupt reaches host only when its enable bit is set.
// - Interrupt level counts only after persisting longer than 40 ns.
// - Serial ROM select field routes ROM data and clock pins per code table.
// - Driver type bit set means push-pull, clear means open-drain.
// - Direction bit set makes the general pin an output, clear an input.
// - Output-only data bits drive output-only pins 3 and 4.
// - General pin configured as output drives its written data bit.
// - Reading general data bits returns sampled pin levels, not written values.
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ns
module gpcfg_top
  import gpcfg_pkg::*;
(
  input logic clk_sys,
  input logic rst_n,
  input logic [7:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input logic [2:0] pin_data_in,
  output logic [2:0] pin_data_out,
  output logic [2:0] pin_data_oe,
  input logic [2:0] indicator_src,
  input gpcfg_rom_t rom_ctl,
  input gpcfg_dbg_t dbg,
  output logic serial_rom_data_pin_out,
  output logic serial_rom_data_pin_oe,
  output logic serial_rom_clock_pin_out,
  output logic [2:0] irq_status_out,
  output logic pin_irq_req
);

  // ==========================================================================
  // Bus slave
  logic wait_r;
  logic wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [31:0] cfg_word_r;
  logic [31:0] cfg_word_nxt;
  logic [2:0] irq_en_r;
  logic [2:0] irq_en_nxt;
  logic [2:0] irq_status_reg_r;
  logic [2:0] irq_status_reg_nxt;
  logic [31:0] be_mask;
  logic req;
  logic commit_wr;
  gpcfg_cfg_t cfg;
  logic [2:0] lvl_filt;
  logic [2:0] lvl_match;

  assign cfg = gpcfg_unpack(cfg_word_r);
  assign req = avs_read || avs_write;
  // Writes land only at the edge where waitrequest is seen low.
  assign commit_wr = avs_write && !wait_r;
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_comb begin
    wait_nxt = !(req && wait_r);
    rdata_nxt = rdata_r;
    cfg_word_nxt = cfg_word_r;
    irq_en_nxt = irq_en_r;
    if (avs_read && wait_r) begin
      if (avs_address == GPCFG_OFS_CFG) begin
        rdata_nxt = {cfg_word_r[31:3], pin_data_in};
      end else if (avs_address == GPCFG_OFS_IRQ_STS) begin
        rdata_nxt = {29'h0000_0000, irq_status_reg_r};
      end else if (avs_address == GPCFG_OFS_IRQ_EN) begin
        rdata_nxt = {29'h0000_0000, irq_en_r};
      end else begin
        rdata_nxt = 32'h0000_0000;
      end
    end
    if (commit_wr) begin
      if (avs_address == GPCFG_OFS_CFG) begin
        cfg_word_nxt = ((cfg_word_r & ~be_mask) | (avs_writedata & be_mask)) & GPCFG_CFG_WMASK;
      end else if (avs_address == GPCFG_OFS_IRQ_EN && avs_byteenable[0]) begin
        irq_en_nxt = avs_writedata[2:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      cfg_word_r <= GPCFG_CFG_RST;
      irq_en_r <= GPCFG_IRQ_RST;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      cfg_word_r <= cfg_word_nxt;
      irq_en_r <= irq_en_nxt;
    end
  end

  // ==========================================================================
  // Pin interrupt levels
  gpcfg_filter #(
    .N(3),
    .CYC(GPCFG_GLITCH_CYC)
  ) u_filter (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .raw(pin_data_in),
    .stable(lvl_filt)
  );

  // Polarity picks the active level; pins in indicator use raise nothing.
  assign lvl_match = ~(lvl_filt ^ cfg.pin_irq_level_polarity) & ~cfg.indicator_output_select;

  logic irq_r;
  logic irq_nxt;

  always_comb begin
    irq_status_reg_nxt = irq_status_reg_r;
    if (commit_wr && avs_address == GPCFG_OFS_IRQ_STS && avs_byteenable[0]) begin
      irq_status_reg_nxt = irq_status_reg_r & ~avs_writedata[2:0];
    end
    // A level seen in the clearing cycle wins over the clear.
    irq_status_reg_nxt = irq_status_reg_nxt | lvl_match;
    irq_nxt = |(irq_status_reg_r & irq_en_r);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_status_reg_r <= GPCFG_IRQ_RST;
      irq_r <= 1'b0;
    end else begin
      irq_status_reg_r <= irq_status_reg_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ==========================================================================
  // Pin drivers
  logic [2:0] pout_r;
  logic [2:0] pout_nxt;
  logic [2:0] poe_r;
  logic [2:0] poe_nxt;
  logic rdo_r;
  logic rdo_nxt;
  logic rdoe_r;
  logic rdoe_nxt;
  logic rck_r;
  logic rck_nxt;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pout_nxt[i] = 1'b0;
      poe_nxt[i] = 1'b0;
      if (cfg.indicator_output_select[i]) begin
        pout_nxt[i] = indicator_src[i];
        poe_nxt[i] = 1'b1;
      end else if (cfg.pin_direction[i]) begin
        if (cfg.pin_driver_type[i]) begin
          pout_nxt[i] = cfg.pin_data[i];
          poe_nxt[i] = 1'b1;
        end else begin
          poe_nxt[i] = !cfg.pin_data[i];
        end
      end
    end
    // Clock routes pass through one flop, so they lag by a cycle of the system clock.
    rdo_nxt = 1'b0;
    rdoe_nxt = 1'b0;
    rck_nxt = 1'b0;
    case (cfg.serial_rom_pin_select)
      GPCFG_ROM_EE: begin
        rdo_nxt = rom_ctl.dout;
        rdoe_nxt = rom_ctl.doe;
        rck_nxt = rom_ctl.clk;
      end
      GPCFG_ROM_GPO: begin
        rdo_nxt = cfg.output_only_data[0];
        rdoe_nxt = 1'b1;
        rck_nxt = cfg.output_only_data[1];
      end
      GPCFG_ROM_OUTPUT_ONLY_PIN_3_DV: begin
        rdo_nxt = cfg.output_only_data[0];
        rdoe_nxt = 1'b1;
        rck_nxt = dbg.rx_dv;
      end
      GPCFG_ROM_TXEN_OUTPUT_ONLY_PIN_4: begin
        rdo_nxt = dbg.tx_en;
        rdoe_nxt = 1'b1;
        rck_nxt = cfg.output_only_data[1];
      end
      GPCFG_ROM_TXEN_DV: begin
        rdo_nxt = dbg.tx_en;
        rdoe_nxt = 1'b1;
        rck_nxt = dbg.rx_dv;
      end
      GPCFG_ROM_CLKS: begin
        rdo_nxt = dbg.tx_clk;
        rdoe_nxt = 1'b1;
        rck_nxt = dbg.rx_clk;
      end
      // Reserved codes leave the data pin released and the clock pin low.
      default: begin
        rdoe_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pout_r <= 3'h0;
      poe_r <= 3'h0;
      rdo_r <= 1'b0;
      rdoe_r <= 1'b0;
      rck_r <= 1'b0;
    end else begin
      pout_r <= pout_nxt;
      poe_r <= poe_nxt;
      rdo_r <= rdo_nxt;
      rdoe_r <= rdoe_nxt;
      rck_r <= rck_nxt;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;
  assign pin_data_out = pout_r;
  assign pin_data_oe = poe_r;
  assign serial_rom_data_pin_out = rdo_r;
  assign serial_rom_data_pin_oe = rdoe_r;
  assign serial_rom_clock_pin_out = rck_r;
  assign irq_status_out = irq_status_reg_r;
  assign pin_irq_req = irq_r;

  // ==========================================================================
  // Checks
  a_bus_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    req && wait_r |=> !wait_r ##1 wait_r)
    else $error("Bus request not answered in one cycle.");

  a_read_pins: assert property (@(posedge clk_sys) disable iff (!rst_n)
    avs_read && !wait_r && avs_address == GPCFG_OFS_CFG |-> rdata_r[2:0] == $past(pin_data_in))
    else $error("Data bits did not return the sampled pin levels.");

  a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cfg_word_r & ~GPCFG_CFG_WMASK) == 32'h0000_0000)
    else $error("Reserved configuration bit became set.");

  a_led_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg.indicator_output_select[1] |=> poe_r[1] && pout_r[1] == $past(indicator_src[1]))
    else $error("Indicator pin not driven from its source.");

  a_push_pull: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cfg.indicator_output_select[0] && cfg.pin_direction[0] && cfg.pin_driver_type[0]
    |=> poe_r[0] && pout_r[0] == $past(cfg.pin_data[0]))
    else $error("Push-pull output does not follow its data bit.");

  a_open_drain: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cfg.indicator_output_select[2] && cfg.pin_direction[2] && !cfg.pin_driver_type[2]
    |=> !pout_r[2] && poe_r[2] == !$past(cfg.pin_data[2]))
    else $error("Open-drain output drives wrong level.");

  a_input_hiz: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cfg.indicator_output_select[0] && !cfg.pin_direction[0] |=> !poe_r[0])
    else $error("Input pin is being driven.");

  a_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lvl_match[1] |=> irq_status_reg_r[1])
    else $error("Active pin level did not set its status bit.");

  a_irq_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq_en_r == 3'h0 |=> !irq_r)
    else $error("Interrupt raised with all enables clear.");

  a_rom_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg.serial_rom_pin_select == GPCFG_ROM_GPO
    |=> rdoe_r && rdo_r == $past(cfg.output_only_data[0]) && rck_r == $past(cfg.output_only_data[1]))
    else $error("Output-only pins not routed to serial ROM pins.");

  c_led_mode: cover property (@(posedge clk_sys) disable iff (!rst_n) cfg.indicator_output_select != 3'h0);
  c_irq_set: cover property (@(posedge clk_sys) disable iff (!rst_n) pin_irq_req);
  c_rom_clks: cover property (@(posedge clk_sys) disable iff (!rst_n) cfg.serial_rom_pin_select == GPCFG_ROM_CLKS);

endmodule

// File: testbench/gpcfg_board_model.sv
// Board model of the general pin wires: pull-ups plus an optional external driver.
`timescale 1ns/1ns
module gpcfg_board_model (
  input wire logic [2:0] pin_data_out,
  input wire logic [2:0] pin_data_oe,
  input wire logic [2:0] ext_en,
  input wire logic [2:0] ext_lvl,
  output logic [2:0] pin_data_in
);
  // A released pin without an external driver floats to the pull-up, so open-drain can only pull a line low.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (pin_data_oe[i]) begin
        pin_data_in[i] = pin_data_out[i];
      end else if (ext_en[i]) begin
        pin_data_in[i] = ext_lvl[i];
      end else begin
        pin_data_in[i] = 1'b1;
      end
    end
  end
endmodule

// File: testbench/tb_gpcfg_top.sv
// Self-checking testbench of the pin function configuration block.
`timescale 1ns/1ns
module tb_gpcfg_top;
  import gpcfg_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] pin_data_in;
  logic [2:0] pin_data_out;
  logic [2:0] pin_data_oe;
  logic [2:0] indicator_src = 3'h0;
  gpcfg_rom_t rom_ctl = '0;
  gpcfg_dbg_t dbg = '0;
  logic rom_dout;
  logic rom_doe;
  logic rom_clk;
  logic [2:0] irq_status_out;
  logic pin_irq_req;
  logic [2:0] ext_en = 3'h7;
  logic [2:0] ext_lvl = 3'h0;
  integer seed = 32'h0000_97ee;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [31:0] w;
  logic [31:0] r;
  logic [5:0] pe;
  logic [2:0] codes [6];

  gpcfg_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_data_in(pin_data_in),
    .pin_data_out(pin_data_out), .pin_data_oe(pin_data_oe), .indicator_src(indicator_src),
    .rom_ctl(rom_ctl), .dbg(dbg), .serial_rom_data_pin_out(rom_dout), .serial_rom_data_pin_oe(rom_doe),
    .serial_rom_clock_pin_out(rom_clk), .irq_status_out(irq_status_out), .pin_irq_req(pin_irq_req));

  gpcfg_board_model board (.pin_data_out(pin_data_out), .pin_data_oe(pin_data_oe), .ext_en(ext_en),
    .ext_lvl(ext_lvl), .pin_data_in(pin_data_in));

  // ==========================================================================
  // Clock, timeout and report
  always #4 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  // ==========================================================================
  // Expectations
  function automatic logic [5:0] pin_exp(input logic [31:0] c, input logic [2:0] src);
    logic [2:0] oe;
    logic [2:0] o;
    for (int i = 0; i < 3; i++) begin
      oe[i] = c[28+i] | (c[8+i] & (c[16+i] | ~c[i]));
      o[i] = c[28+i] ? src[i] : (c[8+i] & c[16+i] & c[i]);
    end
    return {oe, o};
  endfunction

  function automatic logic [2:0] rom_exp(input logic [31:0] c, input gpcfg_rom_t rc, input gpcfg_dbg_t d);
    case (c[22:20])
      3'h0: return {rc.dout, rc.doe, rc.clk};
      3'h1: return {c[3], 1'b1, c[4]};
      3'h3: return {c[3], 1'b1, d.rx_dv};
      3'h5: return {d.tx_en, 1'b1, c[4]};
      3'h6: return {d.tx_en, 1'b1, d.rx_dv};
      3'h7: return {d.tx_clk, 1'b1, d.rx_clk};
      default: return 3'h0;
    endcase
  endfunction

  // ==========================================================================
  // Bus and observation tasks, entered just after a rising edge
  task automatic bus_op(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    // Values read right after an edge are those that edge sampled; only the timeout ends a hung wait.
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk_sys);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic chk_pins(input logic [31:0] c);
    @(negedge clk_sys);
    pe = pin_exp(c, indicator_src);
    chk({23'h0, pin_data_oe, pin_data_out, rom_dout, rom_doe, rom_clk}, {23'h0, pe, rom_exp(c, rom_ctl, dbg)});
    @(posedge clk_sys);
  endtask

  task automatic chk_irq(input logic [3:0] exp, input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({28'h0, pin_irq_req, irq_status_out}, {28'h0, exp});
    @(posedge clk_sys);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    codes = '{GPCFG_ROM_EE, GPCFG_ROM_GPO, GPCFG_ROM_OUTPUT_ONLY_PIN_3_DV, GPCFG_ROM_TXEN_OUTPUT_ONLY_PIN_4, GPCFG_ROM_TXEN_DV,
      GPCFG_ROM_CLKS};
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    bus_op(1'b0, GPCFG_OFS_CFG, 32'h0000_0000, 4'hf);
    chk(rd, GPCFG_CFG_RST);
    chk_pins(32'h0000_0000);
    ext_en <= 3'h0;
    for (int i = 0; i < 40; i++) begin
      w = (i == 0) ? 32'hffff_ffff : $random(seed);
      // Only documented selection codes are ever written.
      w[22:20] = codes[i % 6];
      rom_ctl <= '0;
      bus_op(1'b1, GPCFG_OFS_CFG, w, 4'hf);
      r = $random(seed);
      indicator_src <= r[2:0];
      rom_ctl <= gpcfg_rom_t'(r[5:3]);
      dbg <= gpcfg_dbg_t'(r[9:6]);
      repeat (3) @(posedge clk_sys);
      chk_pins(w);
      bus_op(1'b0, GPCFG_OFS_CFG, 32'h0000_0000, 4'hf);
      chk(rd, (w & GPCFG_CFG_WMASK & 32'hffff_fff8) | {29'h0, (pe[5:3] & pe[2:0]) | ~pe[5:3]});
    end
    bus_op(1'b1, GPCFG_OFS_CFG, 32'h0000_0000, 4'he);
    bus_op(1'b1, 8'h90, 32'hffff_ffff, 4'hf);
    bus_op(1'b0, 8'h90, 32'h0000_0000, 4'hf);
    chk(rd, 32'h0000_0000);
    repeat (3) @(posedge clk_sys);
    bus_op(1'b0, GPCFG_OFS_CFG, 32'h0000_0000, 4'hf);
    chk(rd, (w & 32'h0000_0018) | 32'h0000_0007);
    // Interrupts: pin0 active high, pins 1 and 2 active low, all idle.
    ext_en <= 3'h7;
    ext_lvl <= 3'h6;
    bus_op(1'b1, GPCFG_OFS_CFG, 32'h0100_0000, 4'hf);
    repeat (10) @(posedge clk_sys);
    bus_op(1'b1, GPCFG_OFS_IRQ_STS, 32'h0000_0007, 4'hf);
    bus_op(1'b1, GPCFG_OFS_IRQ_EN, 32'h0000_0007, 4'hf);
    bus_op(1'b0, GPCFG_OFS_IRQ_EN, 32'h0000_0000, 4'hf);
    chk(rd, 32'h0000_0007);
    ext_lvl <= 3'h7;
    repeat (5) @(posedge clk_sys);
    ext_lvl <= 3'h6;
    chk_irq(4'h0, 12);
    ext_lvl <= 3'h4;
    repeat (12) @(posedge clk_sys);
    ext_lvl <= 3'h6;
    chk_irq(4'ha, 3);
    ext_lvl <= 3'h7;
    repeat (12) @(posedge clk_sys);
    ext_lvl <= 3'h6;
    chk_irq(4'hb, 3);
    bus_op(1'b1, GPCFG_OFS_IRQ_EN, 32'h0000_0000, 4'hf);
    chk_irq(4'h3, 3);
    bus_op(1'b1, GPCFG_OFS_IRQ_STS, 32'h0000_0003, 4'hf);
    bus_op(1'b0, GPCFG_OFS_IRQ_STS, 32'h0000_0000, 4'hf);
    chk(rd, 32'h0000_0000);
    chk_irq(4'h0, 2);
    test_done();
  end
endmodule
